// ==== core/bst_core.sv ====
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module bst_core
  import bst_pkg::*;
#(
  parameter int PLL_CYC = PLL_LOCK_CYC
) (
  input wire logic clk_i,                            // System clock, 250 MHz.
  input wire logic rst_i,                            // Asynchronous reset, active high.
  input wire logic hsel_i,                           // AHB slave select.
  input wire logic [31:0] haddr_i,                   // AHB address.
  input wire logic [1:0] htrans_i,                   // AHB transfer type.
  input wire logic hwrite_i,                         // AHB write.
  input wire logic [2:0] hsize_i,                    // AHB size, word only.
  input wire logic [31:0] hwdata_i,                  // AHB write data.
  input wire logic hready_i,                         // AHB ready in.
  output logic [31:0] hrdata_o,                      // AHB read data.
  output logic hreadyout_o,                          // AHB ready out.
  output logic hresp_o,                              // AHB response.
  input wire logic [1:0] brownout_mode_select_i,     // Brown-out mode configuration.
  input wire logic [1:0] brownout_threshold_select_i, // Threshold configuration.
  input wire logic powerup_timer_disable_n_i,        // Power-up timer skipped when high.
  input wire logic [2:0] osc_mode_i,                 // Oscillator configuration.
  input wire logic sleep_i,                          // Device is in Sleep.
  input wire logic pm_wake_i,                        // Pulse, exit from power-managed mode.
  input wire logic ext_reset_pin_n_i,                // External reset pin, active low.
  input wire logic poweron_pulse_i,                  // Analog power-on pulse.
  input wire logic supply_low_i,                     // Comparator, supply below threshold.
  input wire logic internal_slow_osc_i,              // Slow oscillator clock level.
  input wire logic main_osc_i,                       // Main oscillator input level.
  output logic [1:0] brownout_threshold_o,           // Threshold to comparator.
  output logic brownout_monitor_on_o,                // Comparator powered.
  output logic reset_hold_o                          // Device held in reset.
);

  bst_state_t state;
  bst_state_t next_state;
  logic por_s;
  logic low_s;
  logic slow_prev;
  logic main_prev;
  logic slow_tick;
  logic main_tick;
  logic bor_en;
  logic bor_trip;
  logic ost_mode;
  logic pll_mode;
  logic powerup_timer_en;
  logic seq_ost;
  logic soft_en;
  logic poweron_n;
  logic brownout_n;
  logic low_done;
  logic powerup_timer_done;
  logic ost_done;
  logic pll_done;
  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic wr_reset_control_reg;
  logic rd_take;
  logic [31:0] reset_control_reg_val;
  logic [31:0] stat_val;

  // The analog levels are asynchronous to clk_i.
  bst_sync u_por_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(poweron_pulse_i),
    .q_o(por_s)
  );

  bst_sync u_low_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(supply_low_i),
    .q_o(low_s)
  );

  // Oscillator inputs are sampled levels; their rising edges are the ticks.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slow_prev <= 1'b0;
      main_prev <= 1'b0;
    end else begin
      slow_prev <= internal_slow_osc_i;
      main_prev <= main_osc_i;
    end
  end

  assign slow_tick = internal_slow_osc_i && !slow_prev;
  assign main_tick = main_osc_i && !main_prev;

  always_comb begin
    case (brownout_mode_select_i)
      BMODE_OFF: bor_en = 1'b0;
      BMODE_SOFT: bor_en = soft_en;
      BMODE_NOSLEEP: bor_en = !sleep_i;
      BMODE_ON: bor_en = 1'b1;
      default: bor_en = 1'b0;
    endcase
  end

  assign ost_mode = (osc_mode_i == OSC_LP) || (osc_mode_i == OSC_XT) ||
                    (osc_mode_i == OSC_HS) || (osc_mode_i == OSC_PLL);
  assign pll_mode = (osc_mode_i == OSC_PLL);
  assign powerup_timer_en = !powerup_timer_disable_n_i;

  // Short dips below the threshold are ignored until the minimum time passes.
  bst_timer #(
    .LIMIT(BOR_MIN_CYC)
  ) u_low_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(!(bor_en && low_s)),
    .run_i(1'b1),
    .tick_i(1'b1),
    .done_o(low_done)
  );

  assign bor_trip = bor_en && low_s && low_done;

  bst_timer #(
    .LIMIT(POWERUP_TIMER_TICKS)
  ) u_powerup_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(state != ST_POWERUP_TIMER),
    .run_i(1'b1),
    .tick_i(slow_tick),
    .done_o(powerup_timer_done)
  );

  bst_timer #(
    .LIMIT(OST_TICKS)
  ) u_ost (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(state != ST_OST),
    .run_i(1'b1),
    .tick_i(main_tick),
    .done_o(ost_done)
  );

  bst_timer #(
    .LIMIT(PLL_CYC)
  ) u_pll (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(state != ST_PLL),
    .run_i(1'b1),
    .tick_i(1'b1),
    .done_o(pll_done)
  );

  // The start-up timer belongs to power-on and wake-up sequences; brown-out recovery runs it only if ST_RUN was not reached since power-on.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_ost <= 1'b1;
    end else if (por_s) begin
      seq_ost <= 1'b1;
    end else if (state == ST_RUN) begin
      seq_ost <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_POR: begin
        if (!por_s) begin
          if (powerup_timer_en) begin
            next_state = ST_POWERUP_TIMER;
          end else if (ost_mode) begin
            next_state = ST_OST;
          end else begin
            next_state = ST_RUN;
          end
        end
      end
      ST_BOR: begin
        if (!low_s) begin
          if (powerup_timer_en) begin
            next_state = ST_POWERUP_TIMER;
          end else if (seq_ost && ost_mode) begin
            next_state = ST_OST;
          end else begin
            next_state = ST_RUN;
          end
        end
      end
      ST_POWERUP_TIMER: begin
        if (powerup_timer_done) begin
          next_state = (seq_ost && ost_mode) ? ST_OST : ST_RUN;
        end
      end
      ST_OST: begin
        if (ost_done) begin
          next_state = pll_mode ? ST_PLL : ST_RUN;
        end
      end
      ST_PLL: begin
        if (pll_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pm_wake_i && ost_mode) begin
          next_state = ST_OST;
        end
      end
      default: next_state = ST_POR;
    endcase
    if (por_s) begin
      next_state = ST_POR;
    end else if (bor_trip || (state == ST_BOR && low_s)) begin
      next_state = ST_BOR;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_POR;
    end else begin
      state <= next_state;
    end
  end

  // The pin gates only the release; the timers ignore it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_hold_o <= 1'b1;
    end else begin
      reset_hold_o <= (next_state != ST_RUN) || !ext_reset_pin_n_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      brownout_threshold_o <= 2'h0;
      brownout_monitor_on_o <= 1'b0;
    end else begin
      brownout_threshold_o <= brownout_threshold_select_i;
      brownout_monitor_on_o <= bor_en || (state == ST_BOR);
    end
  end

  // AHB slave, zero wait states; writes land in the data phase.
  assign wr_reset_control_reg = wr_pend && (wr_addr == RESET_CONTROL_REG_OFF);
  assign rd_take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ) && !hwrite_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (hready_i) begin
      wr_pend <= hsel_i && (htrans_i == HTRANS_NONSEQ) && hwrite_i;
      wr_addr <= haddr_i[ADDR_W-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_en <= SOFT_EN_RST;
    end else if (por_s) begin
      soft_en <= SOFT_EN_RST;
    end else if (wr_reset_control_reg && brownout_mode_select_i == BMODE_SOFT) begin
      soft_en <= hwdata_i[SOFT_EN_BIT];
    end
  end

  // Hardware clears win over a software set in the same cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      poweron_n <= PON_N_RST;
    end else if (por_s) begin
      poweron_n <= 1'b0;
    end else if (wr_reset_control_reg) begin
      poweron_n <= hwdata_i[PON_N_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      brownout_n <= BRN_N_RST;
    end else if (bor_trip || (por_s && bor_en)) begin
      brownout_n <= 1'b0;
    end else if (wr_reset_control_reg) begin
      brownout_n <= hwdata_i[BRN_N_BIT];
    end
  end

  always_comb begin
    reset_control_reg_val = '0;
    reset_control_reg_val[SOFT_EN_BIT] = soft_en && (brownout_mode_select_i == BMODE_SOFT);
    reset_control_reg_val[PON_N_BIT] = poweron_n;
    reset_control_reg_val[BRN_N_BIT] = brownout_n;
    stat_val = '0;
    stat_val[ST_STATE_LSB +: 3] = state;
    stat_val[ST_HOLD_BIT] = reset_hold_o;
    stat_val[ST_BOREN_BIT] = bor_en;
    stat_val[ST_LOW_BIT] = low_s;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= '0;
    end else if (rd_take) begin
      case (haddr_i[ADDR_W-1:0])
        RESET_CONTROL_REG_OFF: hrdata_o <= reset_control_reg_val;
        STAT_OFF: hrdata_o <= stat_val;
        default: hrdata_o <= '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= HRESP_OKAY;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= HRESP_OKAY;
    end
  end

  sequence s_powerup_timer_ends;
    state == ST_POWERUP_TIMER && powerup_timer_done && !por_s && !bor_trip;
  endsequence

  sequence s_ost_entered;
    state == ST_OST;
  endsequence

  a_mode_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    brownout_mode_select_i == BMODE_OFF |-> !bor_trip && !bor_en)
    else $error("Brown-out active in off mode.");

  a_bor_entry_now: assert property (@(posedge clk_i) disable iff (rst_i)
    bor_trip && !por_s |=> state == ST_BOR)
    else $error("Brown-out trip did not enter reset.");

  a_bor_hold_low: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_BOR && low_s && !por_s |=> state == ST_BOR && reset_hold_o)
    else $error("Brown-out reset left while supply low.");

  a_powerup_timer_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_POWERUP_TIMER && bor_trip && !por_s |=> state == ST_BOR ##1 !powerup_timer_done)
    else $error("Power-up timer not reinitialised.");

  a_soft_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_take && haddr_i[ADDR_W-1:0] == RESET_CONTROL_REG_OFF && brownout_mode_select_i != BMODE_SOFT
    |=> !hrdata_o[SOFT_EN_BIT])
    else $error("Soft enable read nonzero outside software mode.");

  a_sleep_disables: assert property (@(posedge clk_i) disable iff (rst_i)
    brownout_mode_select_i == BMODE_NOSLEEP |-> bor_en == !sleep_i)
    else $error("Hardware mode enable wrong for Sleep.");

  a_por_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    !por_s && !wr_reset_control_reg |=> poweron_n == $past(poweron_n))
    else $error("Power-on flag changed without cause.");

  a_bor_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    bor_trip |=> !brownout_n)
    else $error("Brown-out flag not cleared.");

  a_no_delay_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_POR && !por_s && !powerup_timer_en && !ost_mode && !low_s |=> state == ST_RUN)
    else $error("Start-up delay applied where none is due.");

  a_ost_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    s_powerup_timer_ends and (seq_ost && ost_mode) |=> s_ost_entered ##1 !ost_done)
    else $error("Start-up timer did not follow power-up delay.");

  a_pin_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !ext_reset_pin_n_i |=> reset_hold_o)
    else $error("Reset released while pin low.");

  a_threshold_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 brownout_threshold_o == $past(brownout_threshold_select_i))
    else $error("Threshold not from configuration.");

endmodule

// ==== core/bst_pkg.sv ====
package bst_pkg;

  // Clock rate of clk_i.
  localparam int CLK_MHZ = 250;

  // Least time the supply must stay low before the reset is taken.
  localparam int BOR_MIN_NS = 200;
  localparam int BOR_MIN_CYC = (BOR_MIN_NS * CLK_MHZ + 999) / 1000;

  // Power-up timer: slow oscillator periods counted by an 11-bit counter.
  localparam int POWERUP_TIMER_TICKS = 2048;
  // Oscillator start-up timer: main oscillator cycles.
  localparam int OST_TICKS = 1024;
  // PLL lock delay, counted on clk_i.
  localparam int PLL_LOCK_MS = 2;
  localparam int PLL_LOCK_CYC = PLL_LOCK_MS * 1000 * CLK_MHZ;

  // Register byte offsets.
  localparam logic [7:0] RESET_CONTROL_REG_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam int ADDR_W = 8;

  // reset_control_reg fields.
  localparam int SOFT_EN_BIT = 6;
  localparam int PON_N_BIT = 1;
  localparam int BRN_N_BIT = 0;
  localparam logic SOFT_EN_RST = 1'b1;
  localparam logic PON_N_RST = 1'b0;
  localparam logic BRN_N_RST = 1'b0;

  // Status register fields.
  localparam int ST_STATE_LSB = 0;
  localparam int ST_HOLD_BIT = 3;
  localparam int ST_BOREN_BIT = 4;
  localparam int ST_LOW_BIT = 5;

  // brownout_mode_select encodings.
  localparam logic [1:0] BMODE_OFF = 2'h0;
  localparam logic [1:0] BMODE_SOFT = 2'h1;
  localparam logic [1:0] BMODE_NOSLEEP = 2'h2;
  localparam logic [1:0] BMODE_ON = 2'h3;

  // Oscillator configurations.
  localparam logic [2:0] OSC_LP = 3'h0;
  localparam logic [2:0] OSC_XT = 3'h1;
  localparam logic [2:0] OSC_HS = 3'h2;
  localparam logic [2:0] OSC_PLL = 3'h3;
  localparam logic [2:0] OSC_EC = 3'h4;
  localparam logic [2:0] OSC_RC = 3'h5;
  localparam logic [2:0] OSC_INTIO = 3'h6;

  // AHB constants.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Reset sequence; Gray codes along power-on, power-up, start-up, lock, run.
  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_POWERUP_TIMER = 3'h1,
    ST_OST = 3'h3,
    ST_PLL = 3'h2,
    ST_RUN = 3'h6,
    ST_BOR = 3'h4
  } bst_state_t;

endpackage

// ==== core/bst_sync.sv ====
`timescale 1ns/1ps
module bst_sync (
  input wire logic clk_i,  // System clock.
  input wire logic rst_i,  // Asynchronous reset, active high.
  input wire logic d_i,    // Asynchronous level.
  output logic q_o         // Level in clk_i domain.
);
  logic meta;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ==== core/bst_timer.sv ====
`timescale 1ns/1ps
module bst_timer #(
  parameter int LIMIT = 16
) (
  input wire logic clk_i,    // System clock.
  input wire logic rst_i,    // Asynchronous reset, active high.
  input wire logic clear_i,  // Reinitialise count and done.
  input wire logic run_i,    // Counting allowed.
  input wire logic tick_i,   // One count per high cycle.
  output logic done_o        // Level, LIMIT ticks have passed.
);
  localparam int W = (LIMIT > 1) ? $clog2(LIMIT) : 1;
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);
  logic [W-1:0] count;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
      done_o <= 1'b0;
    end else if (clear_i) begin
      count <= '0;
      done_o <= 1'b0;
    end else if (run_i && tick_i && !done_o) begin
      if (count == LAST) begin
        done_o <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule

// ==== testbench/brownout_and_startup_timers_tb.sv ====
`timescale 1ns/1ps
module brownout_and_startup_timers_tb;
  import bst_pkg::*;
  localparam int SH = 4;
  localparam int MH = 3;
  localparam int PLL_T = 100;
  localparam int POWERUP_TIMER_T = POWERUP_TIMER_TICKS * 2 * SH;
  localparam int OST_T = OST_TICKS * 2 * MH;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic [1:0] bmode = BMODE_ON;
  logic [1:0] thr_sel = 2'h0;
  logic powerup_timer_dis_n = 1'b0;
  logic [2:0] osc_mode = OSC_PLL;
  logic sleep = 1'b0;
  logic pm_wake = 1'b0;
  logic pon = 1'b1;
  logic low = 1'b0;
  logic pin_low = 1'b0;
  logic pon_w, low_w, slow_w, main_w, pin_n_w;
  logic [1:0] thr_o;
  logic mon_o;
  logic reset_hold_o;
  int errors = 0;
  int compares = 0;
  logic [31:0] exp_q[$];
  string name_q[$];
  logic [31:0] res_val;
  logic [31:0] cur_e;
  string cur_n;
  event res_ev;
  logic [1:0] tm [6] = '{BMODE_OFF, BMODE_SOFT, BMODE_SOFT, BMODE_NOSLEEP, BMODE_NOSLEEP, BMODE_ON};
  logic ts [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic tsoft [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic te [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  always #2 clk_i = ~clk_i;

  bst_supply_model #(.SLOW_HALF(SH), .MAIN_HALF(MH)) model_u (.clk_i(clk_i), .pon_i(pon), .low_i(low),
    .pin_low_i(pin_low), .poweron_pulse_o(pon_w), .supply_low_o(low_w), .internal_slow_osc_o(slow_w),
    .main_osc_o(main_w), .ext_reset_pin_n_o(pin_n_w));

  bst_core #(.PLL_CYC(PLL_T)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .brownout_mode_select_i(bmode),
    .brownout_threshold_select_i(thr_sel), .powerup_timer_disable_n_i(powerup_timer_dis_n), .osc_mode_i(osc_mode),
    .sleep_i(sleep), .pm_wake_i(pm_wake), .ext_reset_pin_n_i(pin_n_w), .poweron_pulse_i(pon_w),
    .supply_low_i(low_w), .internal_slow_osc_i(slow_w), .main_osc_i(main_w), .brownout_threshold_o(thr_o),
    .brownout_monitor_on_o(mon_o), .reset_hold_o(reset_hold_o));

  task automatic print_verdict;
    $display("Counts: %0d comparisons, %0d mismatches", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic timeout;
    errors++;
    $display("Error wait bound used up at %0t", $time);
    print_verdict();
  endtask

  task automatic expect_val(input string n, input logic [31:0] e);
    name_q.push_back(n);
    exp_q.push_back(e);
  endtask

  // Results are published one per falling edge so the watcher never misses one.
  task automatic see(input logic [31:0] v);
    @(negedge clk_i);
    res_val = v;
    ->res_ev;
  endtask

  always begin
    @(res_ev);
    compares++;
    if (exp_q.size() == 0) begin
      errors++;
      $display("Error result without expectation, expected none, seen %h", res_val);
    end else begin
      cur_n = name_q.pop_front();
      cur_e = exp_q.pop_front();
      if (res_val !== cur_e) begin
        errors++;
        $display("Error %s expected %h seen %h", cur_n, cur_e, res_val);
      end
    end
  end

  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) begin
      n++;
      if (n > 16) timeout();
      @(posedge clk_i);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= HTRANS_NONSEQ;
    hwrite_i <= wr;
    wait_rdy();
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= wd;
    wait_rdy();
    rd = hrdata_o;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    expect_val(n, e);
    ahb(1'b0, a, 32'h0, d);
    see(d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic wait_hold(input logic lvl, input int lim, output int n);
    n = 0;
    while (reset_hold_o !== lvl) begin
      @(negedge clk_i);
      n++;
      if (n > lim) timeout();
    end
  endtask

  task automatic count_high(input int c, output int hi);
    hi = 0;
    repeat (c) begin
      @(negedge clk_i);
      if (reset_hold_o === 1'b1) hi++;
    end
  endtask

  task automatic in_win(input string n, input int v, input int lo, input int hi);
    expect_val(n, 32'h1);
    see({31'h0, (v >= lo && v <= hi)});
  endtask

  task automatic bo_dip(input int c, output int hi);
    @(posedge clk_i);
    low <= 1'b1;
    count_high(c, hi);
    @(posedge clk_i);
    low <= 1'b0;
  endtask

  task automatic wake;
    @(posedge clk_i);
    pm_wake <= 1'b1;
    @(posedge clk_i);
    pm_wake <= 1'b0;
  endtask

  initial begin
    int n;
    int hi;
    logic [31:0] w;
    void'($urandom(32'hb6467a46));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    pon <= 1'b0;
    wait_hold(1'b0, POWERUP_TIMER_T + OST_T + PLL_T + 40, n);
    in_win("power-up release", n, POWERUP_TIMER_T + OST_T + PLL_T - 4, POWERUP_TIMER_T + OST_T + PLL_T + 16);
    rd_chk("status running", STAT_OFF, 32'h16);
    wake();
    wait_hold(1'b1, 8, n);
    wait_hold(1'b0, OST_T + PLL_T + 40, n);
    in_win("wake release", n, OST_T + PLL_T - 8, OST_T + PLL_T + 16);
    wr(RESET_CONTROL_REG_OFF, 32'h3);
    rd_chk("flags set by software", RESET_CONTROL_REG_OFF, 32'h3);
    $display("Test power-up sequence done");
    @(posedge clk_i);
    pon <= 1'b1;
    pin_low <= 1'b1;
    osc_mode <= OSC_INTIO;
    powerup_timer_dis_n <= 1'b1;
    repeat (5) @(posedge clk_i);
    pon <= 1'b0;
    count_high(200, hi);
    expect_val("hold with pin low", 32'd200);
    see(32'(hi));
    rd_chk("status pin held", STAT_OFF, 32'h1e);
    @(posedge clk_i);
    pin_low <= 1'b0;
    wait_hold(1'b0, 6, n);
    in_win("pin release", n, 0, 6);
    rd_chk("flags after power-on", RESET_CONTROL_REG_OFF, 32'h0);
    rd_chk("unmapped offset", 8'h08, 32'h0);
    wake();
    count_high(40, hi);
    expect_val("wake without crystal", 32'h0);
    see(32'(hi));
    wr(RESET_CONTROL_REG_OFF, 32'h3);
    $display("Test pin and fast start done");
    bo_dip(40, hi);
    expect_val("short dip", 32'h0);
    see(32'(hi));
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      bmode <= tm[i];
      sleep <= ts[i];
      thr_sel <= 2'($urandom());
      w = ($urandom() & 32'hffffffbc) | 32'h3 | {25'h0, tsoft[i], 6'h0};
      wr(RESET_CONTROL_REG_OFF, w);
      expect_val("threshold", {30'h0, thr_sel});
      see({30'h0, thr_o});
      rd_chk("soft enable", RESET_CONTROL_REG_OFF, {25'h0, (tm[i] == BMODE_SOFT) & tsoft[i], 6'h3});
      rd_chk("status enable", STAT_OFF, {27'h0, te[i], 4'h6});
      expect_val("monitor on", {31'h0, te[i]});
      see({31'h0, mon_o});
      expect_val("bus response", {31'h0, HRESP_OKAY});
      see({31'h0, hresp_o});
      bo_dip(150, hi);
      in_win("dip hold", hi, te[i] ? 150 - BOR_MIN_CYC - 8 : 0, te[i] ? 150 - BOR_MIN_CYC : 0);
      if (te[i]) wait_hold(1'b0, 12, n);
      rd_chk("flags after dip", RESET_CONTROL_REG_OFF, {25'h0, (tm[i] == BMODE_SOFT) & tsoft[i], 5'h1, ~te[i]});
    end
    $display("Test brown-out modes done");
    @(posedge clk_i);
    powerup_timer_dis_n <= 1'b0;
    bmode <= BMODE_ON;
    sleep <= 1'b0;
    bo_dip(150, hi);
    repeat (POWERUP_TIMER_T / 2) @(posedge clk_i);
    bo_dip(150, hi);
    expect_val("hold through second dip", 32'd150);
    see(32'(hi));
    wait_hold(1'b0, POWERUP_TIMER_T + 40, n);
    in_win("restarted power-up", n, POWERUP_TIMER_T - 8, POWERUP_TIMER_T + 16);
    rd_chk("brown-out identified", RESET_CONTROL_REG_OFF, 32'h2);
    $display("Test power-up timer restart done");
    print_verdict();
  end
endmodule

// ==== testbench/bst_supply_model.sv ====
`timescale 1ns/1ps
module bst_supply_model #(
  parameter int SLOW_HALF = 4,
  parameter int MAIN_HALF = 3
) (
  input wire logic clk_i,             // Bench clock, times the oscillators.
  input wire logic pon_i,             // Supply still ramping.
  input wire logic low_i,             // Supply below the threshold.
  input wire logic pin_low_i,         // Reset pin pulled low.
  output logic poweron_pulse_o,       // Power-on pulse.
  output logic supply_low_o,          // Comparator output.
  output logic internal_slow_osc_o,   // Slow oscillator.
  output logic main_osc_o,            // Main oscillator.
  output logic ext_reset_pin_n_o      // Reset pin level.
);
  int slow_cnt = 0;
  int main_cnt = 0;
  logic slow_q = 1'b0;
  logic main_q = 1'b0;

  assign poweron_pulse_o = pon_i;
  assign supply_low_o = low_i;
  // The pin has a pull-up, so a released pin reads high.
  assign ext_reset_pin_n_o = pin_low_i ? 1'b0 : 1'b1;
  assign internal_slow_osc_o = slow_q;
  assign main_osc_o = main_q;

  // Both oscillators restart from rest while the supply ramps, which keeps timer phases repeatable.
  always @(posedge clk_i) begin
    if (pon_i) begin
      slow_cnt <= 0;
      main_cnt <= 0;
      slow_q <= 1'b0;
      main_q <= 1'b0;
    end else begin
      if (slow_cnt == SLOW_HALF - 1) begin
        slow_cnt <= 0;
        slow_q <= ~slow_q;
      end else begin
        slow_cnt <= slow_cnt + 1;
      end
      if (main_cnt == MAIN_HALF - 1) begin
        main_cnt <= 0;
        main_q <= ~main_q;
      end else begin
        main_cnt <= main_cnt + 1;
      end
    end
  end
endmodule
